// File: logic/tmc_map.svh
// Purpose: Offsets, reset values, field positions and codes of the
//          modulation control register group.
// Assumes: Byte-wide registers on the internal register port.
// Notes:   Definitions only.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// ==========================================================
// Offsets
`define TMC_ADR_CLK      8'h80
`define TMC_ADR_DIV      8'h85
`define TMC_ADR_DLY      8'h8b
`define TMC_ADR_LED      8'h90
`define TMC_ADR_SMP      8'h92

// ==========================================================
// Reset values
`define TMC_RST_CLK      8'h3f
`define TMC_RST_DIV      8'h01
`define TMC_RST_DLY      8'h01
`define TMC_RST_LED      8'hc4
`define TMC_RST_SMP      8'h30

// ==========================================================
// Field positions and limits
`define TMC_CLK_EXT_BIT  6
`define TMC_LED_INV_BIT  1
`define TMC_LED_OD_BIT   2
`define TMC_LED_TORCH_BIT 4
`define TMC_LED_PP_BIT   5
`define TMC_DIV_MAX      5'h1f
`define TMC_DLY_MAX      4'hc
`define TMC_DLY_LEN      12

// ==========================================================
// Sample mode codes
`define TMC_SMP_SAME     2'h0
`define TMC_SMP_HDR      2'h2
`define TMC_SMP_SUM4     2'h3
`define TMC_INT_SINGLE   2'h0
`define TMC_INT_ROW      2'h2
`define TMC_RD_ONE       2'h0
`define TMC_RD_TWO       2'h1
`define TMC_RD_FOUR      2'h3
`define TMC_ACQ_TOF      2'h0
`define TMC_ACQ_GRAY     2'h3

`endif

// File: logic/tmc_pkg.sv
// Purpose: Types of the modulation control register group.
// Assumes: Constants live in tmc_map.svh.
// Notes:   None.
package tmc_pkg;

   typedef struct packed {
      logic [7:0] clk_src;
      logic [7:0] div;
      logic [7:0] dly;
      logic [7:0] led;
      logic [7:0] smp;
   } tmc_regs_t;

   typedef struct packed {
      logic       binned_hdr_two_sample_mode;
      logic       row_sum_four_sample_mode;
      logic       per_row_integration;
      logic [2:0] readout_count;
      logic       grayscale;
      logic       reserved_code;
   } tmc_mode_t;

   typedef struct packed {
      tmc_regs_t  regs;
      logic [2:0] ext_sync;
      logic [4:0] div_cnt;
      logic [1:0] quarter;
      logic       mod_wave;
      logic [11:0] dly_line;
      logic [7:0] rdata;
   } tmc_state_t;

endpackage

// File: logic/tmc_regs.sv
// Purpose: Modulation clock, demodulation delay, LED drivers and
//          sample mode decode of a time-of-flight sensor.
// Assumes: SYS_CLK stands in for the PLL clock; register port is
//          driven by the serial controller on the same clock.
// Notes:   Open-drain pin drives low only; OE high means conducting.
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_regs (
   input  wire logic              SYS_CLK,
   input  wire logic              RST_B,
   input  wire logic              CE,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic [7:0]        REG_WDATA,
   output logic      [7:0]        REG_RDATA,
   input  wire logic              EXTERNAL_MODULATION_INPUT,
   output logic                   MOD_CLK_TICK,
   output logic                   DEMOD_OUT,
   output logic                   LED_OPEN_DRAIN_OUTPUT_O,
   output logic                   LED_OPEN_DRAIN_OUTPUT_OE,
   output logic                   LED_PUSH_PULL_OUTPUT_O,
   output logic                   LED_PUSH_PULL_OUTPUT_OE,
   output logic                   LED_PUSH_PULL_TERM_EN,
   output tmc_pkg::tmc_mode_t     MODE_CFG
);

   // ==========================================================
   // Reset release
   logic [1:0]          rst_sync_ff;
   logic                rst_n;
   tmc_pkg::tmc_state_t st_ff;
   tmc_pkg::tmc_state_t nxt_st;
   logic                ext_sel;
   logic [4:0]          div_eff;
   logic [3:0]          dly_eff;
   logic                tick;
   logic                led_active;
   logic                led_level;
   logic                od_en;
   logic                pp_en;
   logic                inv;
   logic                torch;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ==========================================================
   // Decode of control fields
   assign ext_sel = st_ff.regs.clk_src[`TMC_CLK_EXT_BIT];
   // Reserved high bits saturate rather than wrap
   assign div_eff = (st_ff.regs.div[7:5] != 3'h0) ? `TMC_DIV_MAX
                                                 : st_ff.regs.div[4:0];
   assign dly_eff = (st_ff.regs.dly > 8'(`TMC_DLY_MAX))
                  ? `TMC_DLY_MAX : st_ff.regs.dly[3:0];
   assign od_en = st_ff.regs.led[`TMC_LED_OD_BIT];
   assign pp_en = st_ff.regs.led[`TMC_LED_PP_BIT];
   assign inv   = st_ff.regs.led[`TMC_LED_INV_BIT];
   assign torch = st_ff.regs.led[`TMC_LED_TORCH_BIT];

   // Internal tick or rising edge of the synchronised external clock
   // At or past the limit, so a lowered divider takes hold at once
   assign tick = ext_sel ? (st_ff.ext_sync[2:1] == 2'h1)
                         : (st_ff.div_cnt >= div_eff);

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ext_sync = {st_ff.ext_sync[1:0], EXTERNAL_MODULATION_INPUT};
      if (ext_sel || tick) begin
         nxt_st.div_cnt = 5'h0;
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 5'h1;
      end
      if (tick) begin
         nxt_st.quarter  = st_ff.quarter + 2'h1;
         nxt_st.mod_wave = ~nxt_st.quarter[1];
      end
      nxt_st.dly_line = {st_ff.dly_line[10:0], st_ff.mod_wave};
      if (REG_WR) begin
         case (REG_ADDR)
            `TMC_ADR_CLK: nxt_st.regs.clk_src = REG_WDATA;
            `TMC_ADR_DIV: nxt_st.regs.div     = REG_WDATA;
            `TMC_ADR_DLY: nxt_st.regs.dly     = REG_WDATA;
            `TMC_ADR_LED: nxt_st.regs.led     = REG_WDATA;
            `TMC_ADR_SMP: nxt_st.regs.smp     = REG_WDATA;
            default:      nxt_st.regs         = st_ff.regs;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            `TMC_ADR_CLK: nxt_st.rdata = st_ff.regs.clk_src;
            `TMC_ADR_DIV: nxt_st.rdata = st_ff.regs.div;
            `TMC_ADR_DLY: nxt_st.rdata = st_ff.regs.dly;
            `TMC_ADR_LED: nxt_st.rdata = st_ff.regs.led;
            `TMC_ADR_SMP: nxt_st.rdata = st_ff.regs.smp;
            default:      nxt_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{regs: '{clk_src: `TMC_RST_CLK, div: `TMC_RST_DIV,
                            dly: `TMC_RST_DLY, led: `TMC_RST_LED,
                            smp: `TMC_RST_SMP},
                    ext_sync: 3'h0, div_cnt: 5'h0, quarter: 2'h0,
                    mod_wave: 1'b1, dly_line: 12'hfff, rdata: 8'h00};
      end else if (CE) begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   assign REG_RDATA    = st_ff.rdata;
   assign MOD_CLK_TICK = tick & CE;
   assign DEMOD_OUT    = (dly_eff == 4'h0) ? st_ff.mod_wave
                       : st_ff.dly_line[dly_eff - 4'h1];

   assign led_active = torch | st_ff.mod_wave;
   assign led_level  = led_active ^ inv;
   // Pin never sourced high; conducting means pulling low
   assign LED_OPEN_DRAIN_OUTPUT_O  = 1'b0;
   assign LED_OPEN_DRAIN_OUTPUT_OE = od_en & led_level;
   assign LED_PUSH_PULL_OUTPUT_O   = pp_en & led_level;
   assign LED_PUSH_PULL_OUTPUT_OE  = pp_en;
   assign LED_PUSH_PULL_TERM_EN    = ~pp_en;

   always_comb begin
      MODE_CFG = '0;
      case (st_ff.regs.smp[1:0])
         `TMC_SMP_HDR:  MODE_CFG.binned_hdr_two_sample_mode = 1'b1;
         `TMC_SMP_SUM4: MODE_CFG.row_sum_four_sample_mode   = 1'b1;
         `TMC_SMP_SAME: MODE_CFG.reserved_code = 1'b0;
         default:       MODE_CFG.reserved_code = 1'b1;
      endcase
      case (st_ff.regs.smp[3:2])
         `TMC_INT_ROW:    MODE_CFG.per_row_integration = 1'b1;
         `TMC_INT_SINGLE: MODE_CFG.per_row_integration = 1'b0;
         default:         MODE_CFG.reserved_code = 1'b1;
      endcase
      case (st_ff.regs.smp[5:4])
         `TMC_RD_ONE:  MODE_CFG.readout_count = 3'h1;
         `TMC_RD_TWO:  MODE_CFG.readout_count = 3'h2;
         `TMC_RD_FOUR: MODE_CFG.readout_count = 3'h4;
         default:      MODE_CFG.reserved_code = 1'b1;
      endcase
      case (st_ff.regs.smp[7:6])
         `TMC_ACQ_GRAY: MODE_CFG.grayscale = 1'b1;
         `TMC_ACQ_TOF:  MODE_CFG.grayscale = 1'b0;
         default:       MODE_CFG.reserved_code = 1'b1;
      endcase
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!rst_n);

   sequence s_int_tick;
      CE && !ext_sel && st_ff.div_cnt == div_eff;
   endsequence

   property p_div_wrap;
      s_int_tick |=> st_ff.div_cnt == 5'h0;
   endproperty
   a_div_wrap: assert property (p_div_wrap)
      else $error("divider did not wrap at limit");

   property p_div_max;
      (CE && !ext_sel) |=> st_ff.div_cnt <= $past(div_eff);
   endproperty
   a_div_max: assert property (p_div_max)
      else $error("divider count above maximum");

   property p_quarter;
      (CE && tick) |=> st_ff.quarter == $past(st_ff.quarter) + 2'h1;
   endproperty
   a_quarter: assert property (p_quarter)
      else $error("quarter phase did not advance");

   property p_wave_hold;
      (CE && !tick) |=> $stable(st_ff.mod_wave);
   endproperty
   a_wave_hold: assert property (p_wave_hold)
      else $error("wave moved without a tick");

   property p_ext_edge;
      (CE && ext_sel && st_ff.ext_sync[2:1] == 2'h1)
         |=> st_ff.quarter != $past(st_ff.quarter);
   endproperty
   a_ext_edge: assert property (p_ext_edge)
      else $error("external edge not followed");

   property p_dly_one;
      (CE && dly_eff == 4'h1 && $past(CE) && $past(dly_eff) == 4'h1)
         |-> DEMOD_OUT == $past(st_ff.mod_wave);
   endproperty
   a_dly_one: assert property (p_dly_one)
      else $error("demodulation not one period late");

   property p_od_off;
      !od_en |-> !LED_OPEN_DRAIN_OUTPUT_OE;
   endproperty
   a_od_off: assert property (p_od_off)
      else $error("open-drain conducts while disabled");

   property p_pp_off;
      !pp_en |-> (!LED_PUSH_PULL_OUTPUT_OE && LED_PUSH_PULL_TERM_EN);
   endproperty
   a_pp_off: assert property (p_pp_off)
      else $error("push-pull driven while disabled");

   property p_torch;
      (torch && !inv && pp_en && od_en)
         |-> LED_PUSH_PULL_OUTPUT_O && LED_OPEN_DRAIN_OUTPUT_OE;
   endproperty
   a_torch: assert property (p_torch)
      else $error("torch not held on");

   property p_invert;
      (pp_en && inv) |-> LED_PUSH_PULL_OUTPUT_O == !led_active;
   endproperty
   a_invert: assert property (p_invert)
      else $error("push-pull not inverted");

   property p_gray;
      (st_ff.regs.smp[7:6] == `TMC_ACQ_GRAY) |-> MODE_CFG.grayscale;
   endproperty
   a_gray: assert property (p_gray)
      else $error("grayscale code not decoded");

   property p_sum4;
      MODE_CFG.row_sum_four_sample_mode
         == (st_ff.regs.smp[1:0] == `TMC_SMP_SUM4);
   endproperty
   a_sum4: assert property (p_sum4)
      else $error("four-sample mode decode wrong");

endmodule

// File: tb/tmc_led_model.sv
// Purpose: Illumination pins and external modulation source.
// Assumes: Open-drain pin pulled up off chip.
// Notes:   Source stands low while run is low.
`timescale 1ns/1ns

module tmc_led_model (
   input  wire logic od_oe,
   input  wire logic pp_o,
   input  wire logic pp_oe,
   input  wire logic term_en,
   input  wire logic run,
   output logic      ext_mod,
   output logic      led_on
);
   logic od_pin;
   logic pp_pin;

   assign od_pin = od_oe ? 1'b0 : 1'b1;
   assign pp_pin = pp_oe ? pp_o : (term_en ? 1'b0 : 1'bz);
   assign led_on = !od_pin || pp_pin === 1'b1;
   // Odd offset keeps pin edges off both clock edges
   initial begin
      ext_mod = 1'b0;
      #7;
      forever begin
         #110;
         ext_mod = run & !ext_mod;
      end
   end
endmodule

// File: tb/tmc_regs_tb.sv
// Purpose: Self-checking bench of the modulation control registers.
// Assumes: One clock; inputs other than the external source change on the falling edge.
// Notes:   Wave is observed on the open-drain enable.
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_regs_tb;
   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               ce = 1'b1;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [7:0]         adr = 8'h00;
   logic [7:0]         wd = 8'h00;
   logic [7:0]         rdat;
   logic               ext, run = 1'b0, tick, dmod, lit;
   logic               od_o, od_oe, pp_o, pp_oe, term;
   tmc_pkg::tmc_mode_t mode;
   int                 miscompares = 0, checks_done = 0, cyc = 0;

   always #20 clk = ~clk;

   tmc_regs u_dut (.SYS_CLK(clk), .RST_B(rst_b), .CE(ce), .REG_WR(wr),
      .REG_RD(rd), .REG_ADDR(adr), .REG_WDATA(wd), .REG_RDATA(rdat),
      .EXTERNAL_MODULATION_INPUT(ext), .MOD_CLK_TICK(tick),
      .DEMOD_OUT(dmod), .LED_OPEN_DRAIN_OUTPUT_O(od_o),
      .LED_OPEN_DRAIN_OUTPUT_OE(od_oe), .LED_PUSH_PULL_OUTPUT_O(pp_o),
      .LED_PUSH_PULL_OUTPUT_OE(pp_oe), .LED_PUSH_PULL_TERM_EN(term),
      .MODE_CFG(mode));

   tmc_led_model u_led (.od_oe(od_oe), .pp_o(pp_o), .pp_oe(pp_oe),
      .term_en(term), .run(run), .ext_mod(ext), .led_on(lit));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(negedge clk);
      wr = w;
      rd = !w;
      adr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
   endtask

   task automatic wl(input logic v);
      int n;
      n = 0;
      while (od_oe !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic gap(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 200);
   endtask

   // ==========================================================
   // Scenarios
   task automatic s_regs;
      logic [7:0] a [5] = '{`TMC_ADR_CLK, `TMC_ADR_DIV, `TMC_ADR_DLY,
                            `TMC_ADR_LED, `TMC_ADR_SMP};
      logic [7:0] r [5] = '{`TMC_RST_CLK, `TMC_RST_DIV, `TMC_RST_DLY,
                            `TMC_RST_LED, `TMC_RST_SMP};
      foreach (a[i]) begin
         acc(1'b0, a[i], 8'h00);
         chk(rdat, r[i]);
      end
      acc(1'b0, 8'h81, 8'h00);
      chk(rdat, 8'h00);
      ce = 1'b0;
      acc(1'b1, `TMC_ADR_DLY, 8'h03);
      ce = 1'b1;
      acc(1'b0, `TMC_ADR_DLY, 8'h00);
      chk(rdat, `TMC_RST_DLY);
      acc(1'b1, `TMC_ADR_DLY, 8'h03);
      acc(1'b0, `TMC_ADR_DLY, 8'h00);
      chk(rdat, 8'h03);
      acc(1'b1, `TMC_ADR_DLY, `TMC_RST_DLY);
   endtask

   task automatic s_div;
      int n;
      logic [7:0] dv [3] = '{8'h00, 8'h03, 8'h1f};
      foreach (dv[i]) begin
         acc(1'b1, `TMC_ADR_DIV, dv[i]);
         gap(n);
         gap(n);
         chk(8'(n), dv[i] + 8'h01);
      end
   endtask

   task automatic s_wave;
      int n;
      acc(1'b1, `TMC_ADR_DIV, 8'h02);
      wl(1'b0);
      wl(1'b1);
      n = 0;
      while (od_oe === 1'b1 && n < 99) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n), 8'h06);
   endtask

   task automatic s_dly;
      logic [12:0] h;
      int d [3] = '{0, 5, 12};
      foreach (d[k]) begin
         acc(1'b1, `TMC_ADR_DLY, 8'(d[k]));
         h = '0;
         for (int c = 0; c < 54; c++) begin
            @(negedge clk);
            h = {h[11:0], od_oe};
            if (c > 29)
               chk({7'h00, dmod}, {7'h00, h[d[k]]});
         end
      end
   endtask

   task automatic s_led;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = {2'b11, i[2], 1'b1, 1'b0, i[1], i[0], 1'b0};
         acc(1'b1, `TMC_ADR_LED, v);
         chk({6'h00, od_o, od_oe}, {7'h00, i[1] & !i[0]});
         chk({6'h00, pp_oe, term}, {6'h00, i[2], !i[2]});
         chk({6'h00, pp_o, lit},
             {6'h00, i[2] & !i[0], (i[1] | i[2]) & !i[0]});
      end
      acc(1'b1, `TMC_ADR_LED, 8'hc2);
      repeat (16) begin
         @(negedge clk);
         chk({7'h00, od_oe}, 8'h00);
      end
      acc(1'b1, `TMC_ADR_LED, `TMC_RST_LED);
   endtask

   task automatic s_mode;
      logic [7:0] s [12] = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h10, 8'h30,
                             8'hc0, 8'h01, 8'h04, 8'h0c, 8'h20, 8'h40};
      logic [7:0] c;
      tmc_pkg::tmc_mode_t m;
      foreach (s[i]) begin
         c = s[i];
         acc(1'b1, `TMC_ADR_SMP, c);
         m = '0;
         m.binned_hdr_two_sample_mode = c[1:0] == `TMC_SMP_HDR;
         m.row_sum_four_sample_mode = c[1:0] == `TMC_SMP_SUM4;
         m.per_row_integration = c[3:2] == `TMC_INT_ROW;
         m.readout_count = c[5:4] == 2'h0 ? 3'h1 : c[5:4] == 2'h1 ? 3'h2 :
                           c[5:4] == 2'h3 ? 3'h4 : 3'h0;
         m.grayscale = c[7:6] == `TMC_ACQ_GRAY;
         m.reserved_code = c[1:0] == 2'h1 || c[2] || c[5:4] == 2'h2 ||
                           ^c[7:6];
         chk(mode, m);
      end
      acc(1'b1, `TMC_ADR_SMP, `TMC_RST_SMP);
   endtask

   task automatic s_ext;
      int n;
      acc(1'b1, `TMC_ADR_CLK, 8'h7f);
      run = 1'b1;
      repeat (4) begin
         @(posedge ext);
         n = 0;
         repeat (5) begin
            @(negedge clk);
            n += int'(tick);
         end
         chk(8'(n), 8'h01);
      end
      run = 1'b0;
      acc(1'b1, `TMC_ADR_CLK, `TMC_RST_CLK);
   endtask

   // Mid-run reset brings the LED drivers back to defaults
   task automatic s_rst;
      acc(1'b1, `TMC_ADR_LED, 8'he4);
      chk({6'h00, pp_oe, term}, 8'h02);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      acc(1'b0, `TMC_ADR_LED, 8'h00);
      chk(rdat, `TMC_RST_LED);
      chk({6'h00, pp_oe, term}, 8'h01);
   endtask

   // ==========================================================
   // Run control
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      s_regs;
      s_div;
      s_wave;
      s_dly;
      s_led;
      s_mode;
      s_ext;
      s_rst;
      end_sim;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim;
      end
   end
endmodule
